// >>> core/ccps_pkg.sv
// package for the chip configuration and pin select register bank
// assumes a 32-bit avalon-mm slave port with byte addressing

package ccps_pkg;

  // --------------------------------------------------------------
  // register indexes, byte address is four times the index
  // --------------------------------------------------------------
  localparam logic [7:0] CCPS_IDX_CHIP_IDENTITY = 8'h20;
  localparam logic [7:0] CCPS_IDX_GLOBAL_CFG    = 8'h21;
  localparam logic [7:0] CCPS_IDX_PIN_SEL_TWO   = 8'h22;

  // --------------------------------------------------------------
  // global_config_one field positions
  // --------------------------------------------------------------
  localparam int CCPS_G1_LOCK_BIT   = 7;
  localparam int CCPS_G1_PARALLEL_IRQ_INPUT_BIT   = 6;
  localparam int CCPS_G1_DMA_WS_LSB = 4;
  localparam int CCPS_G1_IO_WS_LSB  = 2;
  localparam int CCPS_G1_SWRST_BIT  = 1;
  localparam int CCPS_G1_GEN_BIT    = 0;

  // --------------------------------------------------------------
  // pin_select_config_two field positions
  // --------------------------------------------------------------
  localparam int CCPS_P2_PIN2_BIT = 2;
  localparam int CCPS_P2_PIN1_LSB = 0;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic       CCPS_RST_LOCK    = 1'h0;
  localparam logic       CCPS_RST_PARALLEL_IRQ_INPUT    = 1'h0;
  localparam logic [1:0] CCPS_RST_DMA_WS  = 2'h1;
  localparam logic [1:0] CCPS_RST_IO_WS   = 2'h0;
  localparam logic       CCPS_RST_GEN     = 1'h1;
  localparam logic [5:0] CCPS_RST_PIN_SEL = 6'h00;
  localparam logic [1:0] CCPS_RST_PIN1    = 2'h0;

  // --------------------------------------------------------------
  // encodings and wait-state counts
  // --------------------------------------------------------------
  localparam logic [1:0] CCPS_DMA_WS_RSVD  = 2'h0;
  localparam logic [1:0] CCPS_PIN1_GIO34   = 2'h0;
  localparam logic [1:0] CCPS_PIN1_FAN2    = 2'h1;
  localparam logic [1:0] CCPS_PIN1_HOOD    = 2'h2;
  localparam logic [1:0] CCPS_PIN1_RSVD    = 2'h3;
  localparam logic [3:0] CCPS_WS_ZERO      = 4'h0;
  localparam logic [3:0] CCPS_WS_TWO       = 4'h2;
  localparam logic [3:0] CCPS_WS_SIX       = 4'h6;
  localparam logic [3:0] CCPS_WS_TWELVE    = 4'hC;

  function automatic logic [3:0] ccps_ws_count(input logic [1:0] code);
    logic [3:0] n;
    n = CCPS_WS_ZERO;
    unique case (code)
      2'h0: n = CCPS_WS_ZERO;
      2'h1: n = CCPS_WS_TWO;
      2'h2: n = CCPS_WS_SIX;
      2'h3: n = CCPS_WS_TWELVE;
    endcase
    return n;
  endfunction

endpackage

// >>> core/ccps_pin_mux.sv
// one multiplexed pin routed to general i/o or an alternate function
// assumes pad_in_s is already synchronised to clk_sys

`timescale 1ns/1ps

module ccps_pin_mux
  import ccps_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic sel_alt,
  input  wire logic pad_in_s,
  input  wire logic gio_out,
  input  wire logic gio_oe,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      gio_in,
  output logic      alt_in
);

  // --------------------------------------------------------------
  // routing, registered so the pad never sees a mux glitch
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= 1'h0;
      pad_oe  <= 1'h0;
    end else begin
      pad_out <= sel_alt ? alt_out : gio_out;
      pad_oe  <= sel_alt ? alt_oe : gio_oe;
    end
  end

  // deselected function sees a quiet low input
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gio_in <= 1'h0;
      alt_in <= 1'h0;
    end else begin
      gio_in <= ~sel_alt & pad_in_s;
      alt_in <= sel_alt & pad_in_s;
    end
  end

endmodule

// >>> core/ccps_regs.sv
// chip identity, global configuration and pin select register bank
// assumes an avalon-mm master on clk_sys and same-clock logical devices
//
// What this block does
// - lock bit freezes pin selects until hardware reset
// - bit 6 turns pin group into irq inputs
// - dma wait states: reserved, two, six, twelve
// - i/o wait states: zero, two, six, twelve
// - software reset bit reads zero, zero ignored
// - software reset resets devices except lock bits
// - global enable low disables all but wake-up
// - global enable high defers to activate bits
// - read-only identity byte at index 20h
// - pin 7: general io 05 or kbd line 17
// - pin 5: general io 03 or fan out 0
// - pin 4: general io 02 or tach in 0
// - pins 3, 2: general io or fan out 1, tach in 1
// - pin 1: io 34, fan 2, hood lock
// - read-only registers ignore writes
//
// Design decision made here: the Avalon-MM interface to the registers.

`timescale 1ns/1ps

module ccps_regs
  import ccps_pkg::*;
#(
  parameter logic [7:0] CHIP_ID  = 8'h5A, // arbitrary identity value
  parameter int         NUM_LDEV = 8,
  parameter int         NUM_PARALLEL_IRQ_INPUT = 11
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // avalon-mm slave
  input  wire logic [9:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // logical device control
  input  wire logic [NUM_LDEV-1:0] ldev_activate,
  output logic [NUM_LDEV-1:0]      ldev_enable,
  output logic                     ldev_soft_reset,
  output logic                     wake_up_control_unit_reset,
  output logic [3:0]               dma_wait_states,
  output logic [3:0]               io_wait_states,
  output logic                     pin_select_lock,
  output logic                     pins_follow_config_four,
  // parallel irq pin group
  input  wire logic [NUM_PARALLEL_IRQ_INPUT-1:0] parallel_irq_input_group_pad_in,
  output logic [NUM_PARALLEL_IRQ_INPUT-1:0]      parallel_irq_input,
  // multiplexed pins 1 to 7, index is pin number minus one
  input  wire logic [6:0]          pad_in,
  output logic [6:0]               pad_out,
  output logic [6:0]               pad_oe,
  // general i/o: 00..05 at 0..5, 34 at 6
  input  wire logic [6:0]          general_io_out,
  input  wire logic [6:0]          general_io_oe,
  output logic [6:0]               general_io_in,
  // alternate functions
  input  wire logic                kbd_port_line_17_out,
  input  wire logic                kbd_port_line_17_oe,
  output logic                     kbd_port_line_17_in,
  input  wire logic                kbd_port_line_12_out,
  input  wire logic                kbd_port_line_12_oe,
  output logic                     kbd_port_line_12_in,
  input  wire logic                fan_control_out_0,
  input  wire logic                fan_control_out_1,
  input  wire logic                fan_control_out_2,
  input  wire logic                chassis_hood_lock_out,
  output logic                     fan_tach_in_0,
  output logic                     fan_tach_in_1
);

  // --------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------
  if (NUM_LDEV < 1 || NUM_LDEV > 32) begin : g_bad_ldev
    $error("NUM_LDEV must lie between 1 and 32");
  end
  if (NUM_PARALLEL_IRQ_INPUT < 1) begin : g_bad_parallel_irq_input
    $error("NUM_PARALLEL_IRQ_INPUT must be at least 1");
  end

  // --------------------------------------------------------------
  // bus handshake: one wait cycle, answer in the second cycle
  // --------------------------------------------------------------
  logic       ack_r;
  logic       req;
  logic       wr_take;
  logic       wr_low;
  logic [7:0] wdata;
  logic [7:0] rd_byte;
  logic       hit_id;
  logic       hit_g1;
  logic       hit_p2;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_take         = avs_write & ack_r;
  assign wr_low          = wr_take & avs_byteenable[0];
  assign wdata           = avs_writedata[7:0];

  assign hit_id = (avs_address == {CCPS_IDX_CHIP_IDENTITY, 2'h0});
  assign hit_g1 = (avs_address == {CCPS_IDX_GLOBAL_CFG, 2'h0});
  assign hit_p2 = (avs_address == {CCPS_IDX_PIN_SEL_TWO, 2'h0});

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'h0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // --------------------------------------------------------------
  // configuration state
  // --------------------------------------------------------------
  logic       lock_r;
  logic       parallel_irq_input_sel_r;
  logic [1:0] dma_ws_r;
  logic [1:0] io_ws_r;
  logic       gen_en_r;
  logic [5:0] pin_sel_r;
  logic [1:0] pin1_sel_r;
  logic       swrst_r;
  logic       g1_wr;
  logic       p2_wr;
  logic       sw_reset_req;

  assign g1_wr        = wr_low & hit_g1;
  assign p2_wr        = wr_low & hit_p2;
  assign sw_reset_req = g1_wr & wdata[CCPS_G1_SWRST_BIT];

  // lock only rises; nothing but rst_b clears it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= CCPS_RST_LOCK;
    end else if (g1_wr) begin
      lock_r <= lock_r | wdata[CCPS_G1_LOCK_BIT];
    end
  end

  // pin group select, lockable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      parallel_irq_input_sel_r <= CCPS_RST_PARALLEL_IRQ_INPUT;
    end else if (!lock_r) begin
      if (sw_reset_req) begin
        parallel_irq_input_sel_r <= CCPS_RST_PARALLEL_IRQ_INPUT;
      end else if (g1_wr) begin
        parallel_irq_input_sel_r <= wdata[CCPS_G1_PARALLEL_IRQ_INPUT_BIT];
      end
    end
  end

  // wait states and global enable are never locked
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dma_ws_r <= CCPS_RST_DMA_WS;
      io_ws_r  <= CCPS_RST_IO_WS;
      gen_en_r <= CCPS_RST_GEN;
    end else if (sw_reset_req) begin
      dma_ws_r <= CCPS_RST_DMA_WS;
      io_ws_r  <= CCPS_RST_IO_WS;
      gen_en_r <= CCPS_RST_GEN;
    end else if (g1_wr) begin
      // reserved dma code never lands in storage
      if (wdata[CCPS_G1_DMA_WS_LSB +: 2] != CCPS_DMA_WS_RSVD) begin
        dma_ws_r <= wdata[CCPS_G1_DMA_WS_LSB +: 2];
      end
      io_ws_r  <= wdata[CCPS_G1_IO_WS_LSB +: 2];
      gen_en_r <= wdata[CCPS_G1_GEN_BIT];
    end
  end

  // pin selects of the second register, all lockable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_sel_r  <= CCPS_RST_PIN_SEL;
      pin1_sel_r <= CCPS_RST_PIN1;
    end else if (!lock_r) begin
      if (sw_reset_req) begin
        pin_sel_r  <= CCPS_RST_PIN_SEL;
        pin1_sel_r <= CCPS_RST_PIN1;
      end else if (p2_wr) begin
        pin_sel_r <= wdata[7:CCPS_P2_PIN2_BIT];
        if (wdata[CCPS_P2_PIN1_LSB +: 2] != CCPS_PIN1_RSVD) begin
          pin1_sel_r <= wdata[CCPS_P2_PIN1_LSB +: 2];
        end
      end
    end
  end

  // software reset: one-cycle pulse to the logical devices
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      swrst_r <= 1'h0;
    end else begin
      swrst_r <= sw_reset_req;
    end
  end

  assign ldev_soft_reset            = swrst_r;
  assign wake_up_control_unit_reset = swrst_r;
  assign pin_select_lock            = lock_r;
  assign pins_follow_config_four    = ~parallel_irq_input_sel_r;

  // --------------------------------------------------------------
  // read path, data registered in the wait cycle
  // --------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (hit_id) begin
      rd_byte = CHIP_ID;
    end else if (hit_g1) begin
      rd_byte = {lock_r, parallel_irq_input_sel_r, dma_ws_r, io_ws_r,
                 1'h0, gen_en_r};
    end else if (hit_p2) begin
      rd_byte = {pin_sel_r, pin1_sel_r};
    end
  end

  // identity index decodes but has no write path
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // --------------------------------------------------------------
  // decoded controls
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dma_wait_states <= CCPS_WS_TWO;
      io_wait_states  <= CCPS_WS_ZERO;
    end else begin
      dma_wait_states <= ccps_ws_count(dma_ws_r);
      io_wait_states  <= ccps_ws_count(io_ws_r);
    end
  end

  // activate bits are same-clock, so no synchroniser here
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ldev_enable <= '0;
    end else if (!gen_en_r) begin
      ldev_enable <= '0;
    end else begin
      ldev_enable <= ldev_activate;
    end
  end

  // --------------------------------------------------------------
  // pad input synchronisers
  // --------------------------------------------------------------
  logic [6:0]          pad_meta_r;
  logic [6:0]          pad_sync_r;
  logic [NUM_PARALLEL_IRQ_INPUT-1:0] parallel_irq_input_meta_r;
  logic [NUM_PARALLEL_IRQ_INPUT-1:0] parallel_irq_input_sync_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pad_meta_r  <= 7'h00;
      pad_sync_r  <= 7'h00;
      parallel_irq_input_meta_r <= '0;
      parallel_irq_input_sync_r <= '0;
    end else begin
      pad_meta_r  <= pad_in;
      pad_sync_r  <= pad_meta_r;
      parallel_irq_input_meta_r <= parallel_irq_input_group_pad_in;
      parallel_irq_input_sync_r <= parallel_irq_input_meta_r;
    end
  end

  // group pins reach the irq lines only when selected
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      parallel_irq_input <= '0;
    end else begin
      parallel_irq_input <= parallel_irq_input_sel_r ? parallel_irq_input_sync_r : '0;
    end
  end

  // --------------------------------------------------------------
  // pins 2 to 7: two-way muxes, index i is pin i+2
  // --------------------------------------------------------------
  logic [5:0] alt_out;
  logic [5:0] alt_oe;
  logic [5:0] alt_in;

  // tach pins are inputs, so their alternate never drives
  assign alt_out = {kbd_port_line_17_out, kbd_port_line_12_out,
                    fan_control_out_0, 1'h0, fan_control_out_1, 1'h0};
  assign alt_oe  = {kbd_port_line_17_oe, kbd_port_line_12_oe,
                    1'h1, 1'h0, 1'h1, 1'h0};

  for (genvar i = 0; i < 6; i++) begin : g_pin
    ccps_pin_mux u_mux (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .sel_alt  (pin_sel_r[i]),
      .pad_in_s (pad_sync_r[i+1]),
      .gio_out  (general_io_out[i]),
      .gio_oe   (general_io_oe[i]),
      .alt_out  (alt_out[i]),
      .alt_oe   (alt_oe[i]),
      .pad_out  (pad_out[i+1]),
      .pad_oe   (pad_oe[i+1]),
      .gio_in   (general_io_in[i]),
      .alt_in   (alt_in[i])
    );
  end

  assign kbd_port_line_17_in = alt_in[5];
  assign kbd_port_line_12_in = alt_in[4];
  assign fan_tach_in_0       = alt_in[2];
  assign fan_tach_in_1       = alt_in[0];
  // alt_in of pins 3 and 5 unused: those alternates are output only
  // pin 5 drives fan out 0 through alt_out[3]

  // --------------------------------------------------------------
  // pin 1: three-way mux
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pad_out[0]       <= 1'h0;
      pad_oe[0]        <= 1'h0;
      general_io_in[6] <= 1'h0;
    end else begin
      general_io_in[6] <= (pin1_sel_r == CCPS_PIN1_GIO34) & pad_sync_r[0];
      unique case (pin1_sel_r)
        CCPS_PIN1_FAN2: begin
          pad_out[0] <= fan_control_out_2;
          pad_oe[0]  <= 1'h1;
        end
        CCPS_PIN1_HOOD: begin
          pad_out[0] <= chassis_hood_lock_out;
          pad_oe[0]  <= 1'h1;
        end
        default: begin
          // reserved code cannot be stored; falls back to io 34
          pad_out[0] <= general_io_out[6];
          pad_oe[0]  <= general_io_oe[6];
        end
      endcase
    end
  end

endmodule

// >>> testbench/ccps_regs_checker.sv
// checker for the configuration register bank, bound to ccps_regs
// assumes one clock domain and the one-wait avalon slave of the design
`timescale 1ns/1ps
module ccps_regs_checker
  import ccps_pkg::*;
#(
  parameter logic [7:0] CHIP_ID  = 8'h5A, // arbitrary identity value
  parameter int         NUM_LDEV = 8,
  parameter int         NUM_PARALLEL_IRQ_INPUT = 11
)
(
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic [9:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic [NUM_LDEV-1:0] ldev_activate,
  input wire logic [NUM_LDEV-1:0] ldev_enable,
  input wire logic                ldev_soft_reset,
  input wire logic                wake_up_control_unit_reset,
  input wire logic [3:0]          dma_wait_states,
  input wire logic [3:0]          io_wait_states,
  input wire logic                pin_select_lock,
  input wire logic                pins_follow_config_four,
  input wire logic [NUM_PARALLEL_IRQ_INPUT-1:0] parallel_irq_input
);
  // --------------------------------------------------------------
  // accepted transfers
  // --------------------------------------------------------------
  logic wr_g1;
  logic rd_acc;
  assign wr_g1 = avs_write && !avs_waitrequest && avs_address == 10'h084
                 && avs_byteenable[0];
  assign rd_acc = avs_read && !avs_waitrequest;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_id;
    rd_acc && avs_address == 10'h080 |-> avs_readdata == {24'h0, CHIP_ID};
  endproperty
  a_id: assert property (p_id) else $error("identity read wrong");
  property p_swrd;
    rd_acc && avs_address == 10'h084 |->
      !avs_readdata[1] && avs_readdata[31:8] == 24'h0;
  endproperty
  a_swrd: assert property (p_swrd) else $error("reset bit read");
  property p_srst;
    wr_g1 && avs_writedata[1] |=> ldev_soft_reset &&
      wake_up_control_unit_reset ##1 !ldev_soft_reset;
  endproperty
  a_srst: assert property (p_srst) else $error("no reset pulse");
  property p_srst_cause;
    ldev_soft_reset |-> $past(wr_g1 && avs_writedata[1]);
  endproperty
  a_srst_cause: assert property (p_srst_cause) else $error("stray pulse");
  property p_lock;
    $past(pin_select_lock) |-> pin_select_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("lock cleared");
  property p_dma;
    dma_wait_states inside {4'h2, 4'h6, 4'hC};
  endproperty
  a_dma: assert property (p_dma) else $error("dma count bad");
  property p_io;
    io_wait_states inside {4'h0, 4'h2, 4'h6, 4'hC};
  endproperty
  a_io: assert property (p_io) else $error("io count bad");
  property p_en;
    wr_g1 && avs_writedata[1:0] == 2'h0 |-> ##2 ldev_enable == '0;
  endproperty
  a_en: assert property (p_en) else $error("device left enabled");
  property p_sub;
    (ldev_enable & ~$past(ldev_activate)) == '0;
  endproperty
  a_sub: assert property (p_sub) else $error("enable not activated");
  property p_parallel_irq_input;
    pins_follow_config_four [*4] |-> parallel_irq_input == '0;
  endproperty
  a_parallel_irq_input: assert property (p_parallel_irq_input) else $error("irq group leaks");
  c_srst: cover property (ldev_soft_reset);
  c_lock: cover property (pin_select_lock);
  c_parallel_irq_input: cover property (parallel_irq_input != '0);
endmodule

bind ccps_regs ccps_regs_checker #(.CHIP_ID(CHIP_ID), .NUM_LDEV(NUM_LDEV),
  .NUM_PARALLEL_IRQ_INPUT(NUM_PARALLEL_IRQ_INPUT)) chk (.clk_sys, .rst_b, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .ldev_activate, .ldev_enable, .ldev_soft_reset,
  .wake_up_control_unit_reset, .dma_wait_states, .io_wait_states,
  .pin_select_lock, .pins_follow_config_four, .parallel_irq_input);

// >>> testbench/ccps_pad_model.sv
// board around the multiplexed pins and the irq pin group
// assumes no pull resistors: an undriven pad shows what the bench sets
`timescale 1ns/1ps
module ccps_pad_model (
  input wire logic [6:0]  ext_level,
  input wire logic [10:0] parallel_irq_input_level,
  input wire logic [6:0]  pad_out,
  input wire logic [6:0]  pad_oe,
  output logic [6:0]      pad_in,
  output logic [10:0]     parallel_irq_input_pad
);
  // wire level resolved from the device enable and the outside driver
  assign pad_in   = (pad_oe & pad_out) | (~pad_oe & ext_level);
  assign parallel_irq_input_pad = parallel_irq_input_level;
endmodule

// >>> testbench/chip_config_pin_select_regs_test.sv
// self-checking bench for the configuration register bank
// assumes the pad model as far side and an avalon master in tasks
`timescale 1ns/1ps
module chip_config_pin_select_regs_test
  import ccps_pkg::*;
;
  localparam logic [7:0] ID   = 8'h3C; // arbitrary identity value
  localparam logic [9:0] A_ID = 10'h080;
  localparam logic [9:0] A_G1 = 10'h084;
  localparam logic [9:0] A_P2 = 10'h088;
  int seed = 64, failures = 0, cmp_count = 0;
  logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest;
  logic ldev_soft_reset, pin_select_lock, pins_follow_config_four;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [3:0]  avs_byteenable, dma_wait_states, io_wait_states, alt_i;
  logic [7:0]  ldev_activate, ldev_enable, alt_o, p2, rd, s;
  logic [10:0] parallel_irq_input_lvl, parallel_irq_input_pad, parallel_irq_input;
  logic [6:0]  ext, pad_in, pad_out, pad_oe;
  logic [6:0]  general_io_out, general_io_oe, general_io_in;
  logic [24:0] pe;
  logic [1:0]  dm;

  ccps_regs #(.CHIP_ID(ID)) uut (.clk_sys, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .ldev_activate, .ldev_enable, .ldev_soft_reset,
    .wake_up_control_unit_reset(), .dma_wait_states, .io_wait_states,
    .pin_select_lock, .pins_follow_config_four,
    .parallel_irq_input_group_pad_in(parallel_irq_input_pad), .parallel_irq_input, .pad_in, .pad_out,
    .pad_oe, .general_io_out, .general_io_oe, .general_io_in,
    .kbd_port_line_17_out(alt_o[0]), .kbd_port_line_17_oe(alt_o[1]),
    .kbd_port_line_17_in(alt_i[0]), .kbd_port_line_12_out(alt_o[2]),
    .kbd_port_line_12_oe(alt_o[3]), .kbd_port_line_12_in(alt_i[1]),
    .fan_control_out_0(alt_o[4]), .fan_control_out_1(alt_o[5]),
    .fan_control_out_2(alt_o[6]), .chassis_hood_lock_out(alt_o[7]),
    .fan_tach_in_0(alt_i[2]), .fan_tach_in_1(alt_i[3]));
  ccps_pad_model pad (.ext_level(ext), .parallel_irq_input_level(parallel_irq_input_lvl), .pad_out,
    .pad_oe, .pad_in, .parallel_irq_input_pad);

  // --------------------------------------------------------------
  // expectations and checks
  // --------------------------------------------------------------
  function automatic logic [3:0] ws(logic [1:0] c);
    return (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h2 : (c == 2'h2) ? 4'h6 : 4'hC;
  endfunction
  // returns {alt inputs, general io inputs, pad enables, pad outputs}
  function automatic logic [24:0] pin_exp(logic [7:0] s, logic [7:0] a,
      logic [6:0] go, logic [6:0] ge, logic [6:0] x);
    logic [6:0] so, ao, ae, o, e, l, gi;
    int g;
    so = {s[7:2], s[1:0] != 2'h0};
    ao = {a[0], a[2], a[4], 1'b0, a[5], 1'b0, s[1:0] == 2'h1 ? a[6] : a[7]};
    ae = {a[1], a[3], 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 7; k++) begin
      g = (k == 0) ? 6 : k - 1;
      o[k] = so[k] ? ao[k] : go[g];
      e[k] = so[k] ? ae[k] : ge[g];
      l[k] = e[k] ? o[k] : x[k];
      gi[g] = so[k] ? 1'b0 : l[k];
    end
    return {s[2] & l[1], s[4] & l[3], s[6] & l[5], s[7] & l[6], gi, e, o};
  endfunction
  task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_port(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [9:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata[7:0];
    if (n >= 40) failures++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(string n, logic [9:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk_reg(n, e, rd);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    conclude();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {ldev_activate, alt_o, parallel_irq_input_lvl, ext} = '0;
    {general_io_out, general_io_oe} = '0;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdchk("id", A_ID, ID);
    rdchk("g1", A_G1, 8'h11);
    rdchk("p2", A_P2, 8'h00);
    rdchk("hole", 10'h0FC, 8'h00);
    wr(A_ID, 8'hFF);
    rdchk("id ro", A_ID, ID);
    $display("test reset done");
    dm = 2'h1;
    for (int c = 0; c < 16; c++) begin
      wr(A_G1, {2'h0, c[3:0], 2'h1});
      if (c[3:2] != 2'h0) dm = c[3:2];
      rdchk("g1 ws", A_G1, {2'h0, dm, c[1:0], 2'h1});
      chk_port("dma ws", {12'h0, ws(dm)}, {12'h0, dma_wait_states});
      chk_port("io ws", {12'h0, ws(c[1:0])}, {12'h0, io_wait_states});
    end
    $display("test wait states done");
    p2 = 8'h00;
    for (int i = 0; i < 14; i++) begin
      r = $random(seed);
      s = (i == 0) ? 8'hFF : (i == 1) ? 8'h03 : r[7:0];
      avs_byteenable <= (i == 5) ? 4'hE : 4'hF;
      wr(A_P2, s);
      if (i != 5) p2 = {s[7:2], s[1:0] == 2'h3 ? p2[1:0] : s[1:0]};
      rdchk("p2", A_P2, p2);
      r = $random(seed);
      general_io_out <= r[6:0];
      general_io_oe <= r[13:7];
      alt_o <= r[21:14];
      ext <= r[28:22];
      repeat (6) @(posedge clk_sys);
      pe = pin_exp(p2, alt_o, general_io_out, general_io_oe, ext);
      chk_port("pad_out", {9'h0, pe[6:0]}, {9'h0, pad_out});
      chk_port("pad_oe", {9'h0, pe[13:7]}, {9'h0, pad_oe});
      chk_port("gio_in", {9'h0, pe[20:14]}, {9'h0, general_io_in});
      chk_port("alt_in", {12'h0, pe[24:21]}, {12'h0, alt_i});
    end
    $display("test pins done");
    r = $random(seed);
    parallel_irq_input_lvl <= r[10:0];
    ldev_activate <= r[18:11];
    wr(A_G1, 8'h50);
    repeat (6) @(posedge clk_sys);
    chk_port("parallel_irq_input", {5'h0, r[10:0]}, {5'h0, parallel_irq_input});
    chk_port("follow", 16'h0, {15'h0, pins_follow_config_four});
    chk_port("ldev off", 16'h0, {8'h0, ldev_enable});
    wr(A_G1, 8'h11);
    repeat (6) @(posedge clk_sys);
    chk_port("ldev on", {8'h0, r[18:11]}, {8'h0, ldev_enable});
    chk_port("parallel_irq_input off", 16'h0, {5'h0, parallel_irq_input});
    $display("test enable done");
    wr(A_G1, 8'h51);
    wr(A_G1, 8'hD1);
    rdchk("lock", A_G1, 8'hD1);
    wr(A_P2, {~p2[7:2], 2'h1});
    rdchk("p2 locked", A_P2, p2);
    wr(A_G1, 8'h3D);
    rdchk("g1 part", A_G1, 8'hFD);
    wr(A_G1, 8'h03);
    rdchk("soft rst", A_G1, 8'hD1);
    rdchk("p2 kept", A_P2, p2);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdchk("hw rst", A_G1, 8'h11);
    $display("test lock done");
    conclude();
  end
endmodule
